/* oaa_pkg.sv */
`default_nettype none
package oaa_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ACC_W = 40;
  localparam int unsigned INSTR_W = 24;
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_IDX_W = 4;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned OR_OPC_HI = 23;
  localparam int unsigned OR_OPC_LO = 19;
  localparam logic [4:0] OR_OPC = 5'h0E;
  localparam int unsigned OR_BASE_HI = 18;
  localparam int unsigned OR_BASE_LO = 15;
  localparam int unsigned OR_WIDTH_BIT = 14;
  localparam int unsigned OR_DMODE_HI = 13;
  localparam int unsigned OR_DMODE_LO = 11;
  localparam int unsigned OR_DREG_HI = 10;
  localparam int unsigned OR_DREG_LO = 7;
  localparam int unsigned LIT_TAG_HI = 6;
  localparam int unsigned LIT_TAG_LO = 5;
  localparam logic [1:0] LIT_TAG = 2'h3;
  localparam int unsigned LIT_HI = 4;
  localparam int unsigned LIT_LO = 0;
  localparam int unsigned SMODE_HI = 6;
  localparam int unsigned SMODE_LO = 4;
  localparam int unsigned SREG_HI = 3;
  localparam int unsigned SREG_LO = 0;
  localparam int unsigned LAC_OPC_HI = 23;
  localparam int unsigned LAC_OPC_LO = 16;
  localparam logic [7:0] LAC_OPC = 8'hCA;
  localparam int unsigned LAC_ACC_BIT = 15;
  localparam int unsigned LAC_OFS_HI = 14;
  localparam int unsigned LAC_OFS_LO = 11;
  localparam int unsigned LAC_SHIFT_HI = 10;
  localparam int unsigned LAC_SHIFT_LO = 7;

  // ----------------------------------------------------------------
  // Addressing modes and pointer steps
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_DIRECT = 3'h0;
  localparam logic [2:0] MODE_IND = 3'h1;
  localparam logic [2:0] MODE_POST_DEC = 3'h2;
  localparam logic [2:0] MODE_POST_INC = 3'h3;
  localparam logic [2:0] MODE_PRE_DEC = 3'h4;
  localparam logic [2:0] MODE_PRE_INC = 3'h5;
  localparam logic [2:0] MODE_LAST_PTR = 3'h5;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ----------------------------------------------------------------
  // Accumulator constants
  // ----------------------------------------------------------------
  localparam int unsigned ACC_MSB = 39;
  localparam int unsigned ACC_SIGN_LO = 31;
  localparam int unsigned GUARD_W = 8;
  localparam logic [39:0] SAT_POS = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_NEG = 40'hFF80000000;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] new_ptr;
    logic is_mem;
  } oaa_ea_t;

  typedef struct packed {
    logic [REG_COUNT-1:0][WORD_W-1:0] regs;
    logic [ACC_W-1:0] acc_a;
    logic [ACC_W-1:0] acc_b;
    logic neg;
    logic zero;
    logic oa;
    logic ob;
    logic sa;
    logic sb;
    logic wr_en;
    logic [WORD_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic wr_byte;
    logic done;
    logic unsupported;
  } oaa_state_t;

  localparam oaa_state_t STATE_RESET = '0;
endpackage : oaa_pkg
`default_nettype wire

/* oaa_exec.sv */
// Summary of operation
// RL1 - The short-literal OR form ORs the base register with a 5-bit unsigned literal and writes the destination.
// RL2 - The short-literal form is recognised by opcode 0111 0 and the fixed 11 pattern above the five literal bits.
// RL3 - The base operand of both OR forms is always read directly from the register, never through a pointer.
// RL4 - Width bit 0 gives a 16-bit OR and width bit 1 gives a byte OR.
// RL5 - The register OR form ORs the source operand with the base register and stores the result at the destination.
// RL6 - OR source and destination accept direct, indirect, and pre or post increment or decrement addressing.
// RL7 - Both OR forms change only the negative and zero flags.
// RL8 - Each OR instruction is one word and finishes in one cycle, longer only when memory stalls.
// RL9 - The accumulator load reads the source, applies an optional signed preshift and writes the accumulator.
// RL10 - A preshift from -8 to 7 shifts left arithmetically when negative and right arithmetically when positive.
// RL11 - The source is placed in bits 31:16, sign-extended through bit 39, with bits 15:0 zero before shifting.
// RL12 - One opcode bit selects accumulator A or B as the load target.
// RL13 - The load encoding carries offset register, preshift, source mode and source register fields over all registers.
// RL14 - A load that leaves more than sign bits in the guard byte sets that accumulator's overflow flag, and saturation sets its saturation flag.
// RL15 - Negative equals the result's top bit at the chosen width and zero is set exactly when the result is zero.
// RL16 - Pointer modification steps by one for byte operations and by two for word operations.
// RL17 - The combined overflow and saturation flags are the OR of the per-accumulator flags.
`timescale 1ns/10ps
`default_nettype none
module oaa_exec (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [oaa_pkg::INSTR_W-1:0] instr_word,
  output logic instr_ready,
  input wire logic mem_stall,
  output logic [oaa_pkg::WORD_W-1:0] mem_rd_addr,
  input wire logic [oaa_pkg::WORD_W-1:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [oaa_pkg::WORD_W-1:0] mem_wr_addr,
  output logic [oaa_pkg::WORD_W-1:0] mem_wr_data,
  output logic mem_wr_byte,
  input wire logic sat_enable_a,
  input wire logic sat_enable_b,
  input wire logic sat_flags_clear,
  output logic [oaa_pkg::REG_COUNT-1:0][oaa_pkg::WORD_W-1:0] work_regs,
  output logic [oaa_pkg::ACC_W-1:0] acc_a,
  output logic [oaa_pkg::ACC_W-1:0] acc_b,
  output logic negative_flag,
  output logic zero_flag,
  output logic acc_a_overflow_flag,
  output logic acc_b_overflow_flag,
  output logic combined_overflow_flag,
  output logic acc_a_saturation_flag,
  output logic acc_b_saturation_flag,
  output logic combined_saturation_flag,
  output logic instr_done,
  output logic instr_unsupported
);
  import oaa_pkg::*;

  // ----------------------------------------------------------------
  // Effective address helper
  // ----------------------------------------------------------------
  // Offset modes share one adder with the pointer step, so only one mode
  // decode is needed for both instruction families.
  function automatic oaa_ea_t calc_ea(input logic [15:0] ptr, input logic [15:0] ofs,
                                      input logic [2:0] mode, input logic [15:0] step);
    oaa_ea_t ea;
    ea.addr = ptr;
    ea.new_ptr = ptr;
    ea.is_mem = (mode != MODE_DIRECT);
    unique case (mode)
      MODE_DIRECT, MODE_IND: begin
      end
      MODE_POST_DEC: ea.new_ptr = ptr - step; // [RL6] [RL16]
      MODE_POST_INC: ea.new_ptr = ptr + step; // [RL6] [RL16]
      MODE_PRE_DEC: begin
        ea.new_ptr = ptr - step; // [RL6] [RL16]
        ea.addr = ea.new_ptr;
      end
      MODE_PRE_INC: begin
        ea.new_ptr = ptr + step; // [RL6] [RL16]
        ea.addr = ea.new_ptr;
      end
      default: ea.addr = ptr + ofs; // [RL13]
    endcase
    return ea;
  endfunction : calc_ea

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  oaa_state_t cur;
  oaa_state_t next_cur;
  logic take;
  logic is_or;
  logic is_lit;
  logic is_lac;
  logic byte_op;
  logic [15:0] step;
  logic [15:0] src_val;
  logic [15:0] base_val;
  logic [15:0] result;
  logic [3:0] amt;
  logic [3:0] shift_code;
  logic signed [ACC_W-1:0] ext;
  logic signed [ACC_W-1:0] shifted;
  logic [ACC_W-1:0] load_val;
  logic ovf;
  logic sat_on;
  oaa_ea_t src_ea;
  oaa_ea_t dst_ea;

  // Stall only holds off the next instruction; the block has no pipeline.
  assign instr_ready = !mem_stall; // [RL8]
  assign take = instr_valid && !mem_stall;

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  // Register updates are applied in order: source pointer first, then
  // the destination, so a shared pointer sees both modifications.
  always_comb begin
    logic [REG_COUNT-1:0][WORD_W-1:0] regs;
    regs = cur.regs;
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.unsupported = 1'b0;
    next_cur.wr_en = 1'b0;
    mem_rd_addr = '0;
    src_val = '0;
    result = '0;
    amt = '0;
    ovf = 1'b0;
    load_val = '0;
    is_or = (instr_word[OR_OPC_HI:OR_OPC_LO] == OR_OPC);
    is_lit = (instr_word[LIT_TAG_HI:LIT_TAG_LO] == LIT_TAG); // [RL2]
    is_lac = (instr_word[LAC_OPC_HI:LAC_OPC_LO] == LAC_OPC);
    byte_op = instr_word[OR_WIDTH_BIT]; // [RL4]
    step = byte_op ? BYTE_STEP : WORD_STEP; // [RL16]
    src_ea = calc_ea(cur.regs[instr_word[SREG_HI:SREG_LO]], cur.regs[instr_word[LAC_OFS_HI:LAC_OFS_LO]],
                     instr_word[SMODE_HI:SMODE_LO], is_lac ? WORD_STEP : step);
    // Base is always a direct register read.
    base_val = cur.regs[instr_word[OR_BASE_HI:OR_BASE_LO]]; // [RL3]
    shift_code = instr_word[LAC_SHIFT_HI:LAC_SHIFT_LO];
    ext = {{GUARD_W{mem_rd_data[WORD_W-1]}}, mem_rd_data, {WORD_W{1'b0}}}; // [RL11]
    shifted = ext;
    dst_ea = calc_ea(cur.regs[instr_word[OR_DREG_HI:OR_DREG_LO]], '0, instr_word[OR_DMODE_HI:OR_DMODE_LO], step);
    sat_on = instr_word[LAC_ACC_BIT] ? sat_enable_b : sat_enable_a;
    if (take && is_or) begin
      if (!is_lit && instr_word[SMODE_HI:SMODE_LO] > MODE_LAST_PTR) begin
        next_cur.unsupported = 1'b1;
      end else if (instr_word[OR_DMODE_HI:OR_DMODE_LO] > MODE_LAST_PTR) begin
        next_cur.unsupported = 1'b1;
      end else begin
        if (is_lit) begin
          src_val = {{(WORD_W-LIT_HI-1){1'b0}}, instr_word[LIT_HI:LIT_LO]}; // [RL1]
        end else if (src_ea.is_mem) begin
          mem_rd_addr = src_ea.addr; // [RL5] [RL6]
          if (byte_op) begin
            src_val = {{BYTE_W{1'b0}}, src_ea.addr[0] ? mem_rd_data[WORD_W-1:BYTE_W] : mem_rd_data[BYTE_W-1:0]};
          end else begin
            src_val = mem_rd_data;
          end
          regs[instr_word[SREG_HI:SREG_LO]] = src_ea.new_ptr;
        end else begin
          src_val = cur.regs[instr_word[SREG_HI:SREG_LO]]; // [RL5]
        end
        result = base_val | src_val; // [RL1] [RL5]
        dst_ea = calc_ea(regs[instr_word[OR_DREG_HI:OR_DREG_LO]], '0, instr_word[OR_DMODE_HI:OR_DMODE_LO], step);
        if (dst_ea.is_mem) begin
          next_cur.wr_en = 1'b1; // [RL6]
          next_cur.wr_addr = dst_ea.addr;
          next_cur.wr_byte = byte_op;
          next_cur.wr_data = byte_op ? {result[BYTE_W-1:0], result[BYTE_W-1:0]} : result;
          regs[instr_word[OR_DREG_HI:OR_DREG_LO]] = dst_ea.new_ptr;
        end else if (byte_op) begin
          regs[instr_word[OR_DREG_HI:OR_DREG_LO]][BYTE_W-1:0] = result[BYTE_W-1:0]; // [RL4]
        end else begin
          regs[instr_word[OR_DREG_HI:OR_DREG_LO]] = result; // [RL4]
        end
        // Only negative and zero move; accumulator flags are untouched.
        next_cur.neg = byte_op ? result[BYTE_W-1] : result[WORD_W-1]; // [RL7] [RL15]
        next_cur.zero = byte_op ? (result[BYTE_W-1:0] == '0) : (result == '0); // [RL7] [RL15]
        next_cur.done = 1'b1; // [RL8]
      end
    end else if (take && is_lac) begin
      // The read address is driven only for memory modes; direct loads leave it at zero.
      if (src_ea.is_mem) begin
        mem_rd_addr = src_ea.addr; // [RL9] [RL13]
        regs[instr_word[SREG_HI:SREG_LO]] = src_ea.new_ptr;
      end
      if (src_ea.is_mem) begin
        ext = {{GUARD_W{mem_rd_data[WORD_W-1]}}, mem_rd_data, {WORD_W{1'b0}}}; // [RL11]
      end else begin
        ext = {{GUARD_W{cur.regs[instr_word[SREG_HI:SREG_LO]][WORD_W-1]}},
               cur.regs[instr_word[SREG_HI:SREG_LO]], {WORD_W{1'b0}}}; // [RL11]
      end
      // Code 1000 negates to 1000, which reads as an unsigned 8.
      amt = shift_code[3] ? (~shift_code + 4'h1) : shift_code;
      shifted = shift_code[3] ? (ext <<< amt) : (ext >>> amt); // [RL10]
      // Guard byte plus bit 31 must all equal the sign, otherwise overflow.
      ovf = !((&shifted[ACC_MSB:ACC_SIGN_LO]) || !(|shifted[ACC_MSB:ACC_SIGN_LO])); // [RL14]
      load_val = (ovf && sat_on) ? (shifted[ACC_MSB] ? SAT_NEG : SAT_POS) : shifted; // [RL9] [RL14]
      if (instr_word[LAC_ACC_BIT]) begin
        next_cur.acc_b = load_val; // [RL12]
        next_cur.ob = ovf; // [RL14]
        next_cur.sb = cur.sb || (ovf && sat_on); // [RL14]
      end else begin
        next_cur.acc_a = load_val; // [RL12]
        next_cur.oa = ovf; // [RL14]
        next_cur.sa = cur.sa || (ovf && sat_on); // [RL14]
      end
      next_cur.done = 1'b1;
    end else if (take) begin
      next_cur.unsupported = 1'b1;
    end
    // A saturation event in the clearing cycle keeps its flag set.
    if (sat_flags_clear) begin
      next_cur.sa = take && is_lac && !instr_word[LAC_ACC_BIT] && ovf && sat_on;
      next_cur.sb = take && is_lac && instr_word[LAC_ACC_BIT] && ovf && sat_on;
    end
    next_cur.regs = regs;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Every field resets to zero, including the working registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All data outputs are taken straight from the state register.
  assign work_regs = cur.regs;
  assign acc_a = cur.acc_a;
  assign acc_b = cur.acc_b;
  assign negative_flag = cur.neg;
  assign zero_flag = cur.zero;
  assign acc_a_overflow_flag = cur.oa;
  assign acc_b_overflow_flag = cur.ob;
  assign combined_overflow_flag = cur.oa | cur.ob; // [RL17]
  assign acc_a_saturation_flag = cur.sa;
  assign acc_b_saturation_flag = cur.sb;
  assign combined_saturation_flag = cur.sa | cur.sb; // [RL17]
  assign mem_wr_en = cur.wr_en;
  assign mem_wr_addr = cur.wr_addr;
  assign mem_wr_data = cur.wr_data;
  assign mem_wr_byte = cur.wr_byte;
  assign instr_done = cur.done;
  assign instr_unsupported = cur.unsupported;
endmodule : oaa_exec
`default_nettype wire

/* oaa_exec_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks for the execution datapath.
// ----
module oaa_exec_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [oaa_pkg::INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic mem_stall,
  input wire logic mem_wr_en,
  input wire logic [oaa_pkg::ACC_W-1:0] acc_a,
  input wire logic [oaa_pkg::ACC_W-1:0] acc_b,
  input wire logic acc_a_overflow_flag,
  input wire logic acc_b_overflow_flag,
  input wire logic combined_overflow_flag,
  input wire logic acc_a_saturation_flag,
  input wire logic acc_b_saturation_flag,
  input wire logic combined_saturation_flag,
  input wire logic sat_enable_a,
  input wire logic sat_flags_clear,
  input wire logic instr_done,
  input wire logic instr_unsupported
);
  import oaa_pkg::*;
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic take;
  // An instruction is taken only when the stall is low.
  assign take = instr_valid && instr_ready;
  property p_rdy; instr_ready == !mem_stall; endproperty
  a_rdy: assert property (p_rdy) else $error("ready does not follow stall");
  property p_ans; take |=> instr_done ^ instr_unsupported; endproperty
  a_ans: assert property (p_ans) else $error("taken instruction gave no single answer");
  property p_quiet; !take |=> !instr_done && !instr_unsupported && !mem_wr_en; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without a taken instruction");
  property p_cov; combined_overflow_flag == (acc_a_overflow_flag || acc_b_overflow_flag); endproperty
  a_cov: assert property (p_cov) else $error("combined overflow wrong");
  property p_csat; combined_saturation_flag == (acc_a_saturation_flag || acc_b_saturation_flag); endproperty
  a_csat: assert property (p_csat) else $error("combined saturation wrong");
  property p_grd; !acc_a_overflow_flag |-> (acc_a[39:31] == '0 || acc_a[39:31] == '1); endproperty
  a_grd: assert property (p_grd) else $error("guard byte holds data without overflow");
  property p_sat; $rose(acc_a_saturation_flag) |-> acc_a_overflow_flag && $past(sat_enable_a); endproperty
  a_sat: assert property (p_sat) else $error("saturation flag rose without cause");
  property p_stk; acc_a_saturation_flag && !sat_flags_clear |=> acc_a_saturation_flag; endproperty
  a_stk: assert property (p_stk) else $error("saturation flag dropped on its own");
  property p_orx; take && instr_word[OR_OPC_HI:OR_OPC_LO] == OR_OPC |=> $stable(acc_a) && $stable(acc_b); endproperty
  a_orx: assert property (p_orx) else $error("logic OR touched an accumulator");
endmodule : oaa_exec_assertions
`default_nettype wire

/* oaa_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----
// Data memory behind the operand bus, with a stall the bench can raise.
// ----
module oaa_mem_model (
  input wire logic sys_clk,
  input wire logic stall_req,
  input wire logic [15:0] mem_rd_addr,
  output logic [15:0] mem_rd_data,
  output logic mem_stall,
  input wire logic mem_wr_en,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  input wire logic mem_wr_byte
);
  logic [15:0] mem [0:15];
  // Reads answer at once with the aligned word; there is no write forwarding.
  assign mem_rd_data = mem[mem_rd_addr[4:1]];
  assign mem_stall = stall_req;
  // A byte write touches only the lane named by the low address bit.
  always @(posedge sys_clk) begin
    if (mem_wr_en && mem_wr_byte && mem_wr_addr[0]) mem[mem_wr_addr[4:1]][15:8] <= mem_wr_data[15:8];
    else if (mem_wr_en && mem_wr_byte) mem[mem_wr_addr[4:1]][7:0] <= mem_wr_data[7:0];
    else if (mem_wr_en) mem[mem_wr_addr[4:1]] <= mem_wr_data;
  end
endmodule : oaa_mem_model
`default_nettype wire

/* oaa_exec_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module oaa_exec_tb;
  import oaa_pkg::*;
  logic sys_clk = 0, reset = 1, instr_valid = 0, stall_req = 0;
  logic sat_enable_a = 0, sat_enable_b = 0, sat_flags_clear = 0;
  logic [23:0] instr_word = 24'h000000;
  logic instr_ready, mem_stall, mem_wr_en, mem_wr_byte, instr_done, instr_unsupported, negative_flag, zero_flag;
  logic [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  logic [REG_COUNT-1:0][WORD_W-1:0] work_regs;
  logic [39:0] acc_a, acc_b;
  logic acc_a_overflow_flag, acc_b_overflow_flag, combined_overflow_flag;
  logic acc_a_saturation_flag, acc_b_saturation_flag, combined_saturation_flag;
  int n_fail = 0, checks_done = 0, cyc = 0;
  oaa_exec dut_u (.sys_clk, .reset, .instr_valid, .instr_word, .instr_ready, .mem_stall, .mem_rd_addr,
    .mem_rd_data, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .mem_wr_byte, .sat_enable_a, .sat_enable_b,
    .sat_flags_clear, .work_regs, .acc_a, .acc_b, .negative_flag, .zero_flag, .acc_a_overflow_flag,
    .acc_b_overflow_flag, .combined_overflow_flag, .acc_a_saturation_flag, .acc_b_saturation_flag,
    .combined_saturation_flag, .instr_done, .instr_unsupported);
  oaa_mem_model mem_u (.sys_clk, .stall_req, .mem_rd_addr, .mem_rd_data, .mem_stall, .mem_wr_en,
    .mem_wr_addr, .mem_wr_data, .mem_wr_byte);
  // Free-running core clock; inputs move on the falling edge.
  initial forever #12.5 sys_clk = ~sys_clk;
  // A hang is cut short well past the few dozen cycles the run needs.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  function automatic logic [23:0] orr(logic [3:0] b, logic bt, logic [2:0] dm, logic [3:0] d, logic [2:0] sm,
    logic [3:0] s);
    return {OR_OPC, b, bt, dm, d, sm, s};
  endfunction : orr
  function automatic logic [23:0] orl(logic [3:0] b, logic bt, logic [2:0] dm, logic [3:0] d, logic [4:0] k);
    return {OR_OPC, b, bt, dm, d, LIT_TAG, k};
  endfunction : orl
  function automatic logic [23:0] accumulator_load_instr(logic ab, logic [3:0] sh, logic [3:0] s);
    return {LAC_OPC, ab, 4'h0, sh, MODE_DIRECT, s};
  endfunction : accumulator_load_instr
  // One instruction per call; results are judged at the falling edge half a cycle after the take.
  task automatic ex(input logic [23:0] w, input logic ok);
    instr_valid = 1;
    instr_word = w;
    @(negedge sys_clk);
    `CHK({instr_done, instr_unsupported}, {ok, !ok})
  endtask : ex
  task automatic idle;
    instr_valid = 0;
    @(negedge sys_clk);
  endtask : idle
  // Registers start at zero, so they are filled from memory through a pointer.
  task automatic t_load;
    ex(orr(4'hF, 1'h0, MODE_DIRECT, 4'h1, MODE_POST_INC, 4'hE), 1'h1);
    `CHK({work_regs[1], negative_flag, zero_flag, work_regs[14]}, {16'hAAAA, 2'h2, 16'h0002})
    ex(orr(4'hF, 1'h0, MODE_DIRECT, 4'h4, MODE_POST_INC, 4'hE), 1'h1);
    ex(orr(4'hF, 1'h0, MODE_DIRECT, 4'h2, MODE_POST_INC, 4'hE), 1'h1);
    `CHK({work_regs[4], work_regs[2], work_regs[14]}, 48'h1221_9108_0006)
  endtask : t_load
  task automatic t_lit;
    ex(orl(4'h1, 1'h1, MODE_POST_INC, 4'h9, 5'h05), 1'h1);
    `CHK({work_regs[9], negative_flag, zero_flag}, 18'h00006)
    `CHK({mem_wr_en, mem_wr_byte, mem_wr_addr, mem_wr_data[7:0]}, {2'h3, 16'h0000, 8'hAF})
    ex(orl(4'hF, 1'h0, MODE_DIRECT, 4'h9, 5'h00), 1'h1);
    `CHK({work_regs[9], negative_flag, zero_flag, mem_u.mem[0]}, {18'h00001, 16'hAAAF})
    ex(orl(4'h1, 1'h0, MODE_DIRECT, 4'h3, 5'h1F), 1'h1);
    `CHK({work_regs[3], negative_flag, zero_flag}, {16'hAABF, 2'h2})
    ex(orl(4'hF, 1'h1, MODE_DIRECT, 4'h1, 5'h1F), 1'h1);
    `CHK({work_regs[1], negative_flag, zero_flag}, {16'hAA1F, 2'h0})
  endtask : t_lit
  // Pointer modes back to back, including a read right behind a write to it.
  task automatic t_reg;
    ex(orr(4'hF, 1'h0, MODE_DIRECT, 4'h6, MODE_PRE_DEC, 4'hE), 1'h1);
    `CHK({work_regs[6], work_regs[14]}, 32'h9108_0004)
    ex(orr(4'h4, 1'h0, MODE_PRE_INC, 4'hE, MODE_IND, 4'hE), 1'h1);
    `CHK({mem_wr_addr, mem_wr_data, work_regs[14]}, 48'h0006_9329_0006)
    ex(orr(4'h1, 1'h1, MODE_DIRECT, 4'h7, MODE_POST_DEC, 4'hE), 1'h1);
    `CHK({work_regs[7], work_regs[14], negative_flag}, {32'h001F_0005, 1'h0})
    ex(orr(4'hF, 1'h0, 3'h6, 4'h1, MODE_DIRECT, 4'h0), 1'h0);
    ex(24'hFFFFFF, 1'h0);
    `CHK({work_regs[1], mem_u.mem[3]}, 32'hAA1F_9329)
  endtask : t_reg
  task automatic t_lac;
    ex(accumulator_load_instr(1'h1, 4'hD, 4'h4), 1'h1);
    `CHK({acc_b, acc_b_overflow_flag, combined_overflow_flag, acc_b_saturation_flag}, {40'h0091080000, 3'h6})
    `CHK(acc_a, 40'h0000000000)
    ex(accumulator_load_instr(1'h0, 4'h7, 4'h2), 1'h1);
    `CHK({acc_a, acc_a_overflow_flag, acc_a_saturation_flag}, {40'hFFFF221000, 2'h0})
    sat_enable_a = 1;
    ex(accumulator_load_instr(1'h0, 4'h8, 4'h1), 1'h1);
    `CHK({acc_a, acc_a_overflow_flag, acc_a_saturation_flag, combined_saturation_flag}, {SAT_NEG, 3'h7})
    sat_enable_a = 0;
    sat_flags_clear = 1;
    idle;
    `CHK({acc_a_saturation_flag, combined_saturation_flag, acc_b}, {2'h0, 40'h0091080000})
    sat_flags_clear = 0;
    // Memory source through a post-incremented pointer, then register plus offset with saturation on B.
    sat_enable_b = 1;
    ex({LAC_OPC, 1'h1, 4'h0, 4'h0, MODE_POST_INC, 4'h9}, 1'h1);
    `CHK({acc_b, work_regs[9], acc_b_overflow_flag}, {40'hFFAAAF0000, 16'h0002, 1'h0})
    ex({LAC_OPC, 1'h1, 4'h9, 4'hE, 3'h6, 4'h9}, 1'h1);
    `CHK({acc_b, acc_b_overflow_flag, acc_b_saturation_flag, combined_saturation_flag}, {SAT_NEG, 3'h7})
    `CHK(work_regs[9], 16'h0002)
    sat_enable_b = 0;
  endtask : t_lac
  // Nothing may be taken while the memory holds the core off.
  task automatic t_stall;
    stall_req = 1;
    instr_valid = 1;
    instr_word = orl(4'hF, 1'h0, MODE_DIRECT, 4'h5, 5'h0A);
    repeat (3) begin
      @(negedge sys_clk);
      `CHK({instr_done, work_regs[5]}, 17'h00000)
    end
    stall_req = 0;
    ex(orl(4'hF, 1'h0, MODE_DIRECT, 4'h5, 5'h0A), 1'h1);
    `CHK(work_regs[5], 16'h000A)
  endtask : t_stall
  // Main sequence: hold reset, seed memory, run each scenario.
  initial begin
    repeat (20) @(negedge sys_clk);
    reset = 0;
    `CHK({work_regs, acc_a, negative_flag}, '0)
    mem_u.mem[0] = 16'hAAAA;
    mem_u.mem[1] = 16'h1221;
    mem_u.mem[2] = 16'h9108;
    mem_u.mem[3] = 16'h0000;
    t_load;
    t_lit;
    t_reg;
    t_lac;
    t_stall;
    idle;
    test_done;
  end
endmodule : oaa_exec_tb
bind oaa_exec oaa_exec_assertions chk_u (.sys_clk, .reset, .instr_valid, .instr_word, .instr_ready, .mem_stall,
  .mem_wr_en, .acc_a, .acc_b, .acc_a_overflow_flag, .acc_b_overflow_flag, .combined_overflow_flag,
  .acc_a_saturation_flag, .acc_b_saturation_flag, .combined_saturation_flag, .sat_enable_a, .sat_flags_clear,
  .instr_done, .instr_unsupported);
`default_nettype wire
